//--- rtl/pnp_device.sv
// Device end: register map, configuration memory and power state machine.
// Assumes the programmer holds each request until ack and pins are synchronous.
//
// Local design decision: register access over the link from the programmer, not over APB.
`timescale 1ns/1ps
module pnp_device (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // Link to programmer
  pnp_link_if.device                     link,
  // Board pins
  input  wire logic                      systemSupply,
  input  wire logic                      powerOnRequestPin,
  input  wire logic                      modeStandbySelectPin,
  // Power outputs
  output logic [pnp_pkg::RAIL_COUNT-1:0] railEnable,
  output pnp_pkg::pnp_ldo_mode_type      ldo1Mode,
  output pnp_pkg::pnp_ldo_mode_type      ldo2Mode,
  output logic                           dischargeEnable,
  output logic                           oscEnable,
  output pnp_pkg::pnp_state_type         deviceState
);
  import pnp_pkg::*;

  // ****************************************
  // Link decode
  // ****************************************
  logic                    ackReg;
  logic [DATA_W-1:0]       rdataReg;
  logic                    unlockedReg;
  logic                    vDoneReg;
  logic                    vMatchReg;
  pnp_state_type           stateReg;
  pnp_state_type           stateNext;
  logic [DATA_W-1:0]       cfgReg [NVM_COUNT];
  logic [DATA_W-1:0]       nvmReg [NVM_COUNT];
  logic [NVM_COUNT-1:0]    cfgHit;
  logic [NVM_COUNT-1:0]    sameBits;
  logic [DATA_W-1:0]       readMux;
  logic [RAIL_COUNT-1:0]   railNext;

  // One strobe per request: ack in flight masks a second take
  wire take        = link.req & ~ackReg;
  wire wrStrobe    = take & link.write;
  wire rdStrobe    = take & ~link.write;
  wire offHit      = wrStrobe & (link.addr == REG_OFF_REQ);
  wire unlockHit   = wrStrobe & (link.addr == REG_UNLOCK);
  wire validateHit = wrStrobe & (link.addr == REG_VALIDATE);
  // Wrong codes and locked saves fall through without effect
  wire saveHit     = wrStrobe & (link.addr == REG_SAVE) & (link.wdata == SAVE_CODE)
                     & unlockedReg;
  wire supplyUp    = systemSupply;

  // Pin configuration fields
  wire pbMode      = cfgReg[IDX_PIN][PIN_PB_BIT];
  wire autoOn      = cfgReg[IDX_PIN][PIN_AUTO_BIT];
  wire stbyPinMode = cfgReg[IDX_PIN][PIN_STBY_BIT];
  // Push button asks for power on only while low; enable mode asks when high
  wire onRequest   = pbMode ? ~powerOnRequestPin : powerOnRequestPin;
  wire stbyAsk     = stbyPinMode & modeStandbySelectPin;

  // ****************************************
  // Volatile registers and their stored copies
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NVM_COUNT; gi++) begin : g_store
      // Configuration writes count only once the unlock has been seen
      assign cfgHit[gi]   = wrStrobe & (link.addr == NVM_ADDR[gi]) & unlockedReg;
      assign sameBits[gi] = (cfgReg[gi] == nvmReg[gi]);

      // Losing the supply reloads the stored copy as the new default
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          cfgReg[gi] <= NVM_RESET[gi];
        end else if (!supplyUp) begin
          cfgReg[gi] <= nvmReg[gi];
        end else if (cfgHit[gi]) begin
          cfgReg[gi] <= link.wdata;
        end
      end

      // Stored copy changes only on an accepted save
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          nvmReg[gi] <= NVM_RESET[gi];
        end else if (saveHit) begin
          nvmReg[gi] <= cfgReg[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data and handshake
  // ****************************************
  // Unmapped addresses read as zero
  always_comb begin
    readMux = '0;
    if (link.addr == REG_STATUS) begin
      readMux[1:0]         = stateReg;
      readMux[ST_UNLK_BIT] = unlockedReg;
      readMux[ST_MATCH_BIT] = vMatchReg;
      readMux[ST_VDONE_BIT] = vDoneReg;
    end
    for (int i = 0; i < NVM_COUNT; i++) begin
      if (link.addr == NVM_ADDR[i]) begin
        readMux = cfgReg[i];
      end
    end
  end

  // Ack follows the take by one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ackReg   <= 1'b0;
      rdataReg <= '0;
    end else begin
      ackReg   <= take;
      rdataReg <= rdStrobe ? readMux : rdataReg;
    end
  end

  // ****************************************
  // Unlock and validation flags
  // ****************************************
  // Unlock lasts until the supply drops, so a save can follow the edits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      unlockedReg <= 1'b0;
    end else if (!supplyUp) begin
      unlockedReg <= 1'b0;
    end else if (unlockHit) begin
      unlockedReg <= 1'b1;
    end
  end

  // Compare every stored register in one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vDoneReg  <= 1'b0;
      vMatchReg <= 1'b0;
    end else if (validateHit) begin
      vDoneReg  <= 1'b1;
      vMatchReg <= &sameBits;
    end else if (!supplyUp) begin
      vDoneReg  <= 1'b0;
      vMatchReg <= 1'b0;
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      PNP_OFF: begin
        if (supplyUp) begin
          // Without auto start the device waits initialized
          stateNext = autoOn ? PNP_ACTIVE : PNP_INIT;
        end
      end
      PNP_INIT: begin
        if (onRequest) begin
          stateNext = PNP_ACTIVE;
        end
      end
      PNP_ACTIVE: begin
        if (offHit) begin
          stateNext = PNP_INIT;
        end else if (stbyAsk) begin
          stateNext = PNP_STANDBY;
        end
      end
      PNP_STANDBY: begin
        if (offHit) begin
          stateNext = PNP_INIT;
        end else if (!stbyAsk) begin
          stateNext = PNP_ACTIVE;
        end
      end
      default: stateNext = PNP_OFF;
    endcase
    if (!supplyUp) begin
      stateNext = PNP_OFF;
    end
  end

  // Rails follow the state entered at this edge
  always_comb begin
    case (stateNext)
      PNP_ACTIVE:  railNext = cfgReg[IDX_ACTIVE][RAIL_COUNT-1:0];
      PNP_STANDBY: railNext = cfgReg[IDX_STBY][RAIL_COUNT-1:0];
      default:     railNext = '0;
    endcase
  end

  // Load switch wins over the bypass bit
  function automatic pnp_ldo_mode_type ldoModeOf(input logic [DATA_W-1:0] cfg);
    if (cfg[LSW_BIT]) begin
      return PNP_LSW_MODE;
    end
    return cfg[BYP_BIT] ? PNP_BYPASS_MODE : PNP_LDO_MODE;
  endfunction : ldoModeOf

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stateReg        <= PNP_OFF;
      railEnable      <= '0;
      ldo1Mode        <= PNP_LDO_MODE;
      ldo2Mode        <= PNP_LDO_MODE;
      dischargeEnable <= 1'b1;
      oscEnable       <= 1'b0;
    end else begin
      stateReg        <= stateNext;
      railEnable      <= railNext;
      ldo1Mode        <= ldoModeOf(cfgReg[IDX_LDO1]);
      ldo2Mode        <= ldoModeOf(cfgReg[IDX_LDO2]);
      dischargeEnable <= ~(unlockedReg | unlockHit);
      oscEnable       <= unlockedReg | unlockHit;
    end
  end

  assign deviceState = stateReg;
  assign link.ack    = ackReg;
  assign link.rdata  = rdataReg;

endmodule : pnp_device

//--- rtl/pnp_host.sv
// Programmer end: APB command registers driving the device link.
// Assumes an APB master on the same clock and the device answering every request.
`timescale 1ns/1ps
module pnp_host (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to device
  pnp_link_if.host         link
);
  import pnp_pkg::*;

  // ****************************************
  // Command registers
  // ****************************************
  logic [7:0]        targetReg;
  logic [DATA_W-1:0] wdataReg;
  logic [DATA_W-1:0] readReg;
  pnp_op_type        opReg;
  pnp_step_type      stepReg;
  logic              busyReg;
  logic              doneReg;
  logic              errReg;
  logic              progReg;
  logic              reqReg;
  logic              writeReg;
  logic [7:0]        addrReg;
  logic [DATA_W-1:0] linkDataReg;

  wire apbWr     = psel & penable & pwrite;
  wire hitCmd    = paddr == HOST_CMD;
  wire hitTarget = paddr == HOST_TARGET;
  wire hitWdata  = paddr == HOST_WDATA;
  wire hitStatus = paddr == HOST_STATUS;
  wire mapped    = hitCmd | hitTarget | hitWdata | hitStatus;
  wire cmdWr     = apbWr & hitCmd;
  wire [2:0] opIn = pwdata[2:0];
  // Edits and saves are refused until the unlock sequence has finished
  wire needsProg = (opIn == PNP_OP_WRITE) | (opIn == PNP_OP_SAVE);
  wire refuse    = cmdWr & (busyReg | (needsProg & ~progReg) | (opIn > PNP_OP_VALIDATE));
  wire start     = cmdWr & ~refuse;
  wire lastAck   = busyReg & link.ack & (stepReg != PNP_STEP_PROBE)
                   & (stepReg != PNP_STEP_OFF);
  // Probe answer says whether an off request is still needed
  wire inInit    = link.rdata[1:0] == PNP_INIT;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata = '0;
    if (hitTarget) begin
      prdata[7:0] = targetReg;
    end else if (hitWdata) begin
      prdata[DATA_W-1:0] = wdataReg;
    end else if (hitStatus) begin
      prdata[HS_BUSY_BIT] = busyReg;
      prdata[HS_DONE_BIT] = doneReg;
      prdata[HS_ERR_BIT]  = errReg;
      prdata[HS_PROG_BIT] = progReg;
      prdata[HS_RDATA_LSB +: DATA_W] = readReg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      targetReg <= '0;
      wdataReg  <= '0;
    end else begin
      targetReg <= (apbWr & hitTarget) ? pwdata[7:0] : targetReg;
      wdataReg  <= (apbWr & hitWdata) ? pwdata[DATA_W-1:0] : wdataReg;
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle
  wire clrDone = apbWr & hitStatus & pwdata[HS_DONE_BIT];
  wire clrErr  = apbWr & hitStatus & pwdata[HS_ERR_BIT];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      doneReg <= 1'b0;
      errReg  <= 1'b0;
    end else begin
      doneReg <= lastAck | (doneReg & ~clrDone);
      errReg  <= refuse | (errReg & ~clrErr);
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  // Request fields load at a start and change again only at the edge where ack is seen
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busyReg     <= 1'b0;
      progReg     <= 1'b0;
      opReg       <= PNP_OP_READ;
      stepReg     <= PNP_STEP_SINGLE;
      reqReg      <= 1'b0;
      writeReg    <= 1'b0;
      addrReg     <= '0;
      linkDataReg <= '0;
      readReg     <= '0;
    end else if (start) begin
      busyReg <= 1'b1;
      opReg   <= pnp_op_type'(opIn);
      reqReg  <= 1'b1;
      case (opIn)
        PNP_OP_ENTER: begin
          stepReg  <= PNP_STEP_PROBE;
          writeReg <= 1'b0;
          addrReg  <= REG_STATUS;
        end
        PNP_OP_SAVE: begin
          stepReg     <= PNP_STEP_SINGLE;
          writeReg    <= 1'b1;
          addrReg     <= REG_SAVE;
          linkDataReg <= SAVE_CODE;
        end
        PNP_OP_VALIDATE: begin
          stepReg  <= PNP_STEP_SINGLE;
          writeReg <= 1'b1;
          addrReg  <= REG_VALIDATE;
        end
        default: begin
          stepReg     <= PNP_STEP_SINGLE;
          writeReg    <= opIn == PNP_OP_WRITE;
          addrReg     <= targetReg;
          linkDataReg <= wdataReg;
        end
      endcase
    end else if (busyReg & link.ack) begin
      case (stepReg)
        PNP_STEP_PROBE: begin
          readReg  <= link.rdata;
          writeReg <= 1'b1;
          if (inInit) begin
            stepReg <= PNP_STEP_UNLOCK;
            addrReg <= REG_UNLOCK;
          end else begin
            stepReg <= PNP_STEP_OFF;
            addrReg <= REG_OFF_REQ;
          end
        end
        PNP_STEP_OFF: begin
          stepReg <= PNP_STEP_UNLOCK;
          addrReg <= REG_UNLOCK;
        end
        PNP_STEP_UNLOCK: begin
          busyReg <= 1'b0;
          reqReg  <= 1'b0;
          progReg <= 1'b1;
        end
        default: begin
          busyReg <= 1'b0;
          reqReg  <= 1'b0;
          readReg <= writeReg ? readReg : link.rdata;
          // A save closes the session: next edits need a fresh unlock
          progReg <= (opReg == PNP_OP_SAVE) ? 1'b0 : progReg;
        end
      endcase
    end
  end

  assign link.req   = reqReg;
  assign link.write = writeReg;
  assign link.addr  = addrReg;
  assign link.wdata = linkDataReg;

endmodule : pnp_host

//--- rtl/pnp_link_if.sv
// Register-access link between the programmer and the device.
// Assumes a shared clock; the request stays up until ack pulses.
`timescale 1ns/1ps
interface pnp_link_if (
  input wire logic clock
);
  import pnp_pkg::*;

  logic              req;
  logic              write;
  logic [7:0]        addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              ack;

  modport device (input req, input write, input addr, input wdata, output rdata, output ack);
  modport host   (output req, output write, output addr, output wdata, input rdata, input ack);
endinterface : pnp_link_if

//--- rtl/pnp_pkg.sv
// Constants, register map and state types of the configuration-memory sequencer.
// Assumes both ends share one clock and meet through pnp_link_if.
package pnp_pkg;

  // ****************************************
  // Device register map
  // ****************************************
  localparam int          DATA_W        = 8;
  localparam int          RAIL_COUNT    = 7;
  localparam int          NVM_COUNT     = 5;
  localparam logic [7:0]  REG_ACTIVE_EN = 8'h02;
  localparam logic [7:0]  REG_STBY_EN   = 8'h21;
  localparam logic [7:0]  REG_LDO1_CFG  = 8'h07;
  localparam logic [7:0]  REG_LDO2_CFG  = 8'h06;
  localparam logic [7:0]  REG_PIN_CFG   = 8'h44;
  localparam logic [7:0]  REG_SAVE      = 8'h34;
  localparam logic [7:0]  SAVE_CODE     = 8'h0a;
  localparam logic [7:0]  REG_STATUS    = 8'h40;
  localparam logic [7:0]  REG_OFF_REQ   = 8'h41;
  localparam logic [7:0]  REG_UNLOCK    = 8'h42;
  localparam logic [7:0]  REG_VALIDATE  = 8'h43;

  // Index of each stored register in the shadow arrays
  localparam int IDX_ACTIVE = 0;
  localparam int IDX_STBY   = 1;
  localparam int IDX_LDO1   = 2;
  localparam int IDX_LDO2   = 3;
  localparam int IDX_PIN    = 4;
  localparam logic [7:0] NVM_ADDR [NVM_COUNT] = '{8'h02, 8'h21, 8'h07, 8'h06, 8'h44};
  localparam logic [7:0] NVM_RESET [NVM_COUNT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

  // Field positions
  localparam int LSW_BIT      = 7;
  localparam int BYP_BIT      = 6;
  localparam int PIN_PB_BIT   = 0;
  localparam int PIN_AUTO_BIT = 1;
  localparam int PIN_STBY_BIT = 2;
  localparam int ST_UNLK_BIT  = 2;
  localparam int ST_MATCH_BIT = 3;
  localparam int ST_VDONE_BIT = 4;

  typedef enum logic [1:0] {
    PNP_OFF     = 2'b00,
    PNP_INIT    = 2'b01,
    PNP_ACTIVE  = 2'b10,
    PNP_STANDBY = 2'b11
  } pnp_state_type;

  typedef enum logic [1:0] {
    PNP_LDO_MODE    = 2'b00,
    PNP_BYPASS_MODE = 2'b01,
    PNP_LSW_MODE    = 2'b10
  } pnp_ldo_mode_type;

  // ****************************************
  // Programmer register map on APB
  // ****************************************
  localparam logic [7:0] HOST_CMD    = 8'h00;
  localparam logic [7:0] HOST_TARGET = 8'h04;
  localparam logic [7:0] HOST_WDATA  = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0c;
  localparam int HS_BUSY_BIT  = 0;
  localparam int HS_DONE_BIT  = 1;
  localparam int HS_ERR_BIT   = 2;
  localparam int HS_PROG_BIT  = 3;
  localparam int HS_RDATA_LSB = 8;

  typedef enum logic [2:0] {
    PNP_OP_READ     = 3'b000,
    PNP_OP_WRITE    = 3'b001,
    PNP_OP_ENTER    = 3'b010,
    PNP_OP_SAVE     = 3'b011,
    PNP_OP_VALIDATE = 3'b100
  } pnp_op_type;

  typedef enum logic [1:0] {
    PNP_STEP_PROBE  = 2'b00,
    PNP_STEP_OFF    = 2'b01,
    PNP_STEP_UNLOCK = 2'b10,
    PNP_STEP_SINGLE = 2'b11
  } pnp_step_type;

endpackage : pnp_pkg

//--- testbench/pmic_nvm_program_sequencer_tb.sv
// Self-checking bench: programmer and device joined over the link, driven over APB.
// Assumes the package, link interface and both design ends are compiled first.
`timescale 1ns/1ps
module pmic_nvm_program_sequencer_tb;
  import pnp_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  systemSupply = 1'b1;
  logic                  powerOnRequestPin = 1'b1;  // Held high like a pull-up
  logic                  modeStandbySelectPin = 1'b0;
  logic [RAIL_COUNT-1:0] railEnable;
  pnp_ldo_mode_type      ldo1Mode;
  pnp_ldo_mode_type      ldo2Mode;
  logic                  dischargeEnable;
  logic                  oscEnable;
  pnp_state_type         deviceState;
  int                    nErrors = 0;
  int                    nCompared = 0;
  int                    cycleCount = 0;
  logic [7:0]            activeVal;
  logic [7:0]            stbyVal;
  logic [7:0]            ldo1Val;
  logic [7:0]            ldo2Val;
  logic [31:0]           st;
  logic [31:0]           q;
  logic                  e;

  always #5 clock = ~clock;

  // ****************************************
  // Both ends, their link and its checker
  // ****************************************
  pnp_link_if link (.clock(clock));
  pnp_device pnp_device_i (.clock(clock), .rst_n(rst_n), .link(link),
    .systemSupply(systemSupply), .powerOnRequestPin(powerOnRequestPin),
    .modeStandbySelectPin(modeStandbySelectPin), .railEnable(railEnable),
    .ldo1Mode(ldo1Mode), .ldo2Mode(ldo2Mode), .dischargeEnable(dischargeEnable),
    .oscEnable(oscEnable), .deviceState(deviceState));
  pnp_host pnp_host_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  pnp_link_properties pnp_link_properties_i (.clock(clock), .rst_n(rst_n),
    .req(link.req), .write(link.write), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack));

  // ****************************************
  // Compare, expectation and bus tasks
  // ****************************************
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chkBit(input string name, input logic exp, input logic got);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask : chkBit

  function automatic logic [7:0] statusExp(input pnp_state_type s, input logic u,
                                           input logic m, input logic v);
    return {3'h0, v, m, u, s};
  endfunction : statusExp

  // Load-switch select wins over the bypass select
  function automatic logic [7:0] ldoExp(input logic [7:0] cfg);
    if (cfg[LSW_BIT]) return {6'h0, PNP_LSW_MODE};
    return cfg[BYP_BIT] ? {6'h0, PNP_BYPASS_MODE} : {6'h0, PNP_LDO_MODE};
  endfunction : ldoExp

  // One APB transfer; the leading edge keeps back-to-back calls from double driving
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issue one host operation and poll until it is no longer busy
  task automatic cmd(input pnp_op_type op, input logic [7:0] tgt, input logic [7:0] wd,
                     output logic [31:0] s);
    logic [31:0] r;
    logic        x;
    apb(1'b1, HOST_TARGET, {24'h0, tgt}, r, x);
    apb(1'b1, HOST_WDATA, {24'h0, wd}, r, x);
    apb(1'b1, HOST_STATUS, 32'h6, r, x);
    apb(1'b1, HOST_CMD, {29'h0, op}, r, x);
    do begin
      apb(1'b0, HOST_STATUS, 32'h0, s, x);
    end while (s[HS_BUSY_BIT] !== 1'b0);
  endtask : cmd

  task automatic waitState(input pnp_state_type want);
    int n;
    n = 0;
    while (deviceState !== want && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk8("deviceState", {6'h0, want}, {6'h0, deviceState});
  endtask : waitState

  task automatic summarize();
    $display("compared %0d, mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Hang guard, well above the thousand or so cycles the run needs
  always @(posedge clock) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      nErrors++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h75c0));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (20) @(posedge clock);
    waitState(PNP_INIT);
    chkBit("dischargeEnable", 1'b1, dischargeEnable);
    chkBit("oscEnable", 1'b0, oscEnable);
    chk8("railEnable", 8'h00, {1'b0, railEnable});
    apb(1'b0, 8'h20, 32'h0, q, e);
    chkBit("pslverr", 1'b1, e);
    chk8("prdata", 8'h00, q[7:0]);
    cmd(PNP_OP_WRITE, REG_ACTIVE_EN, 8'h7f, st);
    chkBit("hostErr", 1'b1, st[HS_ERR_BIT]);
    cmd(PNP_OP_READ, REG_ACTIVE_EN, 8'h00, st);
    chk8("activeEnable", 8'h00, st[15:8]);
    $display("test locked_access done");
    cmd(PNP_OP_ENTER, 8'h00, 8'h00, st);
    chkBit("hostProg", 1'b1, st[HS_PROG_BIT]);
    chkBit("dischargeEnable", 1'b0, dischargeEnable);
    chkBit("oscEnable", 1'b1, oscEnable);
    cmd(PNP_OP_READ, REG_STATUS, 8'h00, st);
    chk8("deviceStatus", statusExp(PNP_INIT, 1'b1, 1'b0, 1'b0), st[15:8]);
    $display("test unlock done");
    // Every select code in the first four passes, random after
    for (int i = 0; i < 6; i++) begin
      activeVal = {1'b0, 7'($urandom)} | 8'h01;
      stbyVal = {1'b0, 7'($urandom)};
      ldo1Val = (i < 4) ? {2'(i), 6'($urandom)} : 8'($urandom);
      ldo2Val = {ldo1Val[6], ldo1Val[7], 6'($urandom)};
      cmd(PNP_OP_WRITE, REG_ACTIVE_EN, activeVal, st);
      cmd(PNP_OP_WRITE, REG_STBY_EN, stbyVal, st);
      cmd(PNP_OP_WRITE, REG_LDO1_CFG, ldo1Val, st);
      cmd(PNP_OP_WRITE, REG_LDO2_CFG, ldo2Val, st);
      cmd(PNP_OP_READ, REG_ACTIVE_EN, 8'h00, st);
      chk8("activeEnable", activeVal, st[15:8]);
      cmd(PNP_OP_READ, REG_STBY_EN, 8'h00, st);
      chk8("standbyEnable", stbyVal, st[15:8]);
      chk8("ldo1Mode", ldoExp(ldo1Val), {6'h0, ldo1Mode});
      chk8("ldo2Mode", ldoExp(ldo2Val), {6'h0, ldo2Mode});
    end
    cmd(PNP_OP_WRITE, REG_PIN_CFG, 8'h05, st);
    $display("test register_writes done");
    cmd(PNP_OP_VALIDATE, 8'h00, 8'h00, st);
    cmd(PNP_OP_READ, REG_STATUS, 8'h00, st);
    chk8("deviceStatus", statusExp(PNP_INIT, 1'b1, 1'b0, 1'b1), st[15:8]);
    cmd(PNP_OP_WRITE, REG_SAVE, 8'h05, st);
    cmd(PNP_OP_VALIDATE, 8'h00, 8'h00, st);
    cmd(PNP_OP_READ, REG_STATUS, 8'h00, st);
    chk8("deviceStatus", statusExp(PNP_INIT, 1'b1, 1'b0, 1'b1), st[15:8]);
    cmd(PNP_OP_SAVE, REG_SAVE, SAVE_CODE, st);
    chkBit("hostProg", 1'b0, st[HS_PROG_BIT]);
    cmd(PNP_OP_VALIDATE, 8'h00, 8'h00, st);
    cmd(PNP_OP_READ, REG_STATUS, 8'h00, st);
    chk8("deviceStatus", statusExp(PNP_INIT, 1'b1, 1'b1, 1'b1), st[15:8]);
    $display("test save_validate done");
    systemSupply <= 1'b0;
    waitState(PNP_OFF);
    systemSupply <= 1'b1;
    waitState(PNP_INIT);
    cmd(PNP_OP_READ, REG_ACTIVE_EN, 8'h00, st);
    chk8("activeEnable", activeVal, st[15:8]);
    cmd(PNP_OP_READ, REG_STBY_EN, 8'h00, st);
    chk8("standbyEnable", stbyVal, st[15:8]);
    $display("test power_cycle done");
    powerOnRequestPin <= 1'b0;
    waitState(PNP_ACTIVE);
    chk8("railEnable", activeVal, {1'b0, railEnable});
    powerOnRequestPin <= 1'b1;
    modeStandbySelectPin <= 1'b1;
    waitState(PNP_STANDBY);
    chk8("railEnable", stbyVal, {1'b0, railEnable});
    modeStandbySelectPin <= 1'b0;
    waitState(PNP_ACTIVE);
    cmd(PNP_OP_ENTER, 8'h00, 8'h00, st);
    waitState(PNP_INIT);
    chk8("railEnable", 8'h00, {1'b0, railEnable});
    $display("test power_states done");
    // Supply loss clears the device unlock; the host keeps its own
    systemSupply <= 1'b0;
    waitState(PNP_OFF);
    systemSupply <= 1'b1;
    waitState(PNP_INIT);
    cmd(PNP_OP_WRITE, REG_ACTIVE_EN, 8'h00, st);
    chkBit("hostErr", 1'b0, st[HS_ERR_BIT]);
    cmd(PNP_OP_READ, REG_ACTIVE_EN, 8'h00, st);
    chk8("activeEnable", activeVal, st[15:8]);
    cmd(PNP_OP_READ, 8'h50, 8'h00, st);
    chk8("unmappedRead", 8'h00, st[15:8]);
    $display("test device_lock done");
    summarize();
  end
endmodule : pmic_nvm_program_sequencer_tb

//--- testbench/pnp_link_properties.sv
// Concurrent checks on the link between the programmer and the device.
// Assumes one clock domain and the synchronous active-low reset of the bench.
`timescale 1ns/1ps
module pnp_link_properties (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Link signals
  input wire logic       req,
  input wire logic       write,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Decoding and helper counter
  // ****************************************
  // A take is a request that no acknowledge answers yet
  wire logic       take     = req && !ack;
  wire logic       readTake = take && !write;
  wire logic       unlockHit = take && write && (addr == 8'h42);
  logic      [7:0] sinceUnlock_reg;
  wire logic [7:0] sinceUnlock_next = unlockHit ? 8'h00 :
                                      (sinceUnlock_reg == 8'hff) ? 8'hff : sinceUnlock_reg + 8'h01;

  // Saturates so a long run never wraps back into the window
  always_ff @(posedge clock) begin
    if (!rst_n) sinceUnlock_reg <= 8'hff;
    else        sinceUnlock_reg <= sinceUnlock_next;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_ack_after_take: assert property (take |=> ack)
    else $error("ack missing one cycle after a take");
  a_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack stood longer than one cycle");
  a_ack_has_take: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a preceding take");
  a_req_held_stable: assert property (take |=> req && $stable({write, addr, wdata}))
    else $error("request dropped or changed before ack");
  a_take_spacing: assert property (take |=> !take)
    else $error("two takes on consecutive edges");
  a_unmapped_zero: assert property (readTake && addr >= 8'h45 |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_keeps: assert property (!readTake |=> $stable(rdata))
    else $error("read data changed without a read");
  a_unlock_shown: assert property (
    readTake && addr == 8'h40 && sinceUnlock_reg < 8'd30 |=> rdata[2])
    else $error("status misses unlock soon after unlock");

  // Main scenarios reached
  c_save_code: cover property (take && write && addr == 8'h34 && wdata == 8'h0a);
  c_unlock: cover property (unlockHit);
  c_status_read: cover property (readTake && addr == 8'h40);
endmodule : pnp_link_properties
